// ### src/fwrs_ctrl.v
// Purpose: Command interpreter for wrapped reads, software reset and discovery reads
// Assumes: cs_n, sck and io_in come from the pins and are synchronised here
// Notes:   Serial clock is sampled by ref_clk; edges are found after synchronising
`include "fwrs_regs.vh"

module fwrs_ctrl #(
  parameter [7:0] MFR_CODE = 8'h5a, // Arbitrary value
  parameter       ADDR_W   = 24
) (
  input  wire              ref_clk,
  input  wire              resetn,
  input  wire              ce,
  input  wire              cs_n,
  input  wire              sck,
  input  wire [3:0]        io_in,
  output reg  [3:0]        io_out,
  output reg  [3:0]        io_oe,
  input  wire              quad_enable_bit,
  input  wire              wel_set,
  input  wire              susp_set,
  input  wire              susp_clr,
  input  wire [7:0]        mem_data,
  output wire [ADDR_W-1:0] mem_addr,
  output reg               quad_command_mode,
  output reg               wrap_disable_bit,
  output wire [1:0]        wrap_size_bits,
  output wire [1:0]        wrap_length_select,
  output reg  [1:0]        dummy_clock_select,
  output reg               write_enable_latch,
  output reg               suspend_flag,
  output reg               reset_enabled,
  output reg               reset_busy,
  output reg               vol_clear
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam integer RST_CYC = (`FWRS_T_RST_NS + `FWRS_REF_CLK_NS - 1) / `FWRS_REF_CLK_NS;

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_OP    = 3'd1;
  localparam [2:0] ST_ADDR  = 3'd2;
  localparam [2:0] ST_DUMMY = 3'd3;
  localparam [2:0] ST_DATA  = 3'd4;
  localparam [2:0] ST_WBITS = 3'd5;
  localparam [2:0] ST_PARAM = 3'd6;
  localparam [2:0] ST_IGN   = 3'd7;

  localparam [2:0] K_LIN   = 3'd0;
  localparam [2:0] K_WRAPW = 3'd1;
  localparam [2:0] K_WRAPP = 3'd2;
  localparam [2:0] K_DISC  = 3'd3;
  localparam [2:0] K_WSET  = 3'd4;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [5:0]        sync1_r;
  reg  [5:0]        sync2_r;
  reg               sck_d_r;
  reg               cs_d_r;
  wire              cs_s;
  wire              sck_s;
  wire [3:0]        io_s;
  wire              sck_rise;
  wire              sck_fall;
  wire              cs_fall;

  assign cs_s     = sync2_r[5];
  assign sck_s    = sync2_r[4];
  assign io_s     = sync2_r[3:0];
  assign sck_rise = sck_s & ~sck_d_r & ~cs_s;
  assign sck_fall = ~sck_s & sck_d_r & ~cs_s;
  assign cs_fall  = ~cs_s & cs_d_r;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 6'h3f;
      sync2_r <= 6'h3f;
      sck_d_r <= 1'b1;
      cs_d_r  <= 1'b1;
    end else if (ce) begin
      sync1_r <= {cs_n, sck, io_in};
      sync2_r <= sync1_r;
      sck_d_r <= sck_s;
      cs_d_r  <= cs_s;
    end
  end

  // ----------------------------------------------------------------
  // Command state
  // ----------------------------------------------------------------
  reg  [2:0]        state_r;
  reg  [5:0]        cnt_r;
  reg  [31:0]       rx_r;
  reg               lane4_r;
  reg  [2:0]        kind_r;
  reg  [5:0]        dmy_r;
  reg  [ADDR_W-1:0] addr_r;
  reg  [7:0]        tx_r;
  reg  [2:0]        bit_r;
  reg               tx_go_r;
  reg  [1:0]        wlen_r;
  reg  [9:0]        busy_cnt_r;
  wire [31:0]       rx_nxt;
  wire [7:0]        op;
  wire              last;
  wire [5:0]        p_dummy;
  wire [7:0]        byte_src;
  wire              do_wrap;

  assign rx_nxt             = lane4_r ? {rx_r[27:0], io_s} : {rx_r[30:0], io_s[0]};
  assign op                 = rx_nxt[7:0];
  assign last               = (cnt_r == 6'h01);
  assign mem_addr           = addr_r;
  assign wrap_length_select = wlen_r;
  assign wrap_size_bits     = wlen_r;
  assign do_wrap            = (kind_r == K_WRAPP) |
                              ((kind_r == K_WRAPW) & ~wrap_disable_bit);

  // Dummy count from the select field
  assign p_dummy = (dummy_clock_select == 2'b11) ? `FWRS_DMY_P11 :
                   (dummy_clock_select == 2'b10) ? `FWRS_DMY_P10 :
                   `FWRS_DMY_P0X;

  // Discovery byte: header, else erased
  function [7:0] disc_byte;
    input [`FWRS_DISC_AW-1:0] a;
    reg   [191:0]             hdr;
    begin
      hdr = `FWRS_DISC_HDR;
      if (a >= `FWRS_DISC_HDR_LEN) begin
        disc_byte = `FWRS_DISC_ERASED;
      end else if (a[4:0] == `FWRS_DISC_MFR_IDX) begin
        disc_byte = MFR_CODE;
      end else begin
        disc_byte = hdr[{a[4:0], 3'b000} +: 8];
      end
    end
  endfunction

  assign byte_src = (kind_r == K_DISC) ? disc_byte(addr_r[`FWRS_DISC_AW-1:0]) : mem_data;

  // Next read address, wrapping inside an aligned section
  function [ADDR_W-1:0] next_addr;
    input [ADDR_W-1:0] a;
    input              wrap;
    input [1:0]        sel;
    reg   [7:0]        m;
    reg   [7:0]        inc;
    begin
      m   = (`FWRS_WRAP_MIN_LEN << sel) - 8'h01;
      inc = a[7:0] + 8'h01;
      if (wrap) begin
        next_addr = {a[ADDR_W-1:8], (a[7:0] & ~m) | (inc & m)};
      end else begin
        next_addr = a + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r            <= ST_IDLE;
      cnt_r              <= 6'h00;
      rx_r               <= 32'h0;
      lane4_r            <= 1'b0;
      kind_r             <= K_LIN;
      dmy_r              <= 6'h00;
      addr_r             <= {ADDR_W{1'b0}};
      tx_r               <= 8'h00;
      bit_r              <= 3'h0;
      tx_go_r            <= 1'b0;
      io_out             <= 4'h0;
      io_oe              <= 4'h0;
      quad_command_mode  <= 1'b0;
      wrap_disable_bit   <= `FWRS_WDIS_RST;
      wlen_r             <= `FWRS_WLEN_RST;
      dummy_clock_select <= `FWRS_DSEL_RST;
      write_enable_latch <= 1'b0;
      suspend_flag       <= 1'b0;
      reset_enabled      <= 1'b0;
      reset_busy         <= 1'b0;
      busy_cnt_r         <= 10'h000;
      vol_clear          <= 1'b0;
    end else if (ce) begin
      vol_clear <= 1'b0;
      if (wel_set) begin
        write_enable_latch <= 1'b1;
      end
      if (susp_set) begin
        suspend_flag <= 1'b1;
      end else if (susp_clr) begin
        suspend_flag <= 1'b0;
      end
      if (busy_cnt_r != 10'h000) begin
        busy_cnt_r <= busy_cnt_r - 10'h001;
      end else begin
        reset_busy <= 1'b0;
      end
      if (cs_s) begin
        state_r <= ST_IDLE;
        io_oe   <= 4'h0;
        io_out  <= 4'h0;
        tx_go_r <= 1'b0;
      end else if (cs_fall) begin
        state_r <= reset_busy ? ST_IGN : ST_OP;
        lane4_r <= quad_command_mode;
        cnt_r   <= quad_command_mode ? `FWRS_CLK_BYTE4 : `FWRS_CLK_BYTE1;
        kind_r  <= K_LIN;
      end else if (sck_rise) begin
        rx_r  <= rx_nxt;
        cnt_r <= cnt_r - 6'h01;
        case (state_r)
          ST_OP: begin
            if (last) begin
              state_r       <= ST_IGN;
              reset_enabled <= (op == `FWRS_OP_RST_EN);
              if (op == `FWRS_OP_RST && reset_enabled) begin
                quad_command_mode  <= 1'b0;
                wrap_disable_bit   <= `FWRS_WDIS_RST;
                wlen_r             <= `FWRS_WLEN_RST;
                dummy_clock_select <= `FWRS_DSEL_RST;
                write_enable_latch <= wel_set;
                suspend_flag       <= susp_set;
                vol_clear          <= 1'b1;
                reset_busy         <= 1'b1;
                busy_cnt_r         <= RST_CYC[9:0];
              end else if (op == `FWRS_OP_QPI_EN) begin
                if (!quad_command_mode && quad_enable_bit) begin
                  quad_command_mode <= 1'b1;
                end
              end else if (op == `FWRS_OP_QPI_DIS) begin
                quad_command_mode <= 1'b0;
              end else if (op == `FWRS_OP_WRAP_SET) begin
                if (!quad_command_mode && quad_enable_bit) begin
                  state_r <= ST_ADDR;
                  lane4_r <= 1'b1;
                  cnt_r   <= `FWRS_CLK_ADDR4;
                  kind_r  <= K_WSET;
                end
              end else if (op == `FWRS_OP_RD_PARAM) begin
                if (quad_command_mode) begin
                  state_r <= ST_PARAM;
                  cnt_r   <= `FWRS_CLK_BYTE4;
                end
              end else if (op == `FWRS_OP_WRAP_RD) begin
                if (quad_command_mode) begin
                  state_r <= ST_ADDR;
                  cnt_r   <= `FWRS_CLK_ADDR4;
                  dmy_r   <= p_dummy;
                  kind_r  <= K_WRAPP;
                end
              end else if (op == `FWRS_OP_FAST_RD) begin
                state_r <= ST_ADDR;
                cnt_r   <= quad_command_mode ? `FWRS_CLK_ADDR4 : `FWRS_CLK_ADDR1;
                dmy_r   <= quad_command_mode ? p_dummy : `FWRS_DMY_FAST1;
              end else if (op == `FWRS_OP_QIO_RD) begin
                if (quad_command_mode || quad_enable_bit) begin
                  state_r <= ST_ADDR;
                  lane4_r <= 1'b1;
                  cnt_r   <= `FWRS_CLK_ADDR4;
                  dmy_r   <= quad_command_mode ? p_dummy : `FWRS_DMY_QIO;
                  kind_r  <= K_WRAPW;
                end
              end else if (op == `FWRS_OP_WQIO_RD) begin
                if (!quad_command_mode && quad_enable_bit) begin
                  state_r <= ST_ADDR;
                  lane4_r <= 1'b1;
                  cnt_r   <= `FWRS_CLK_ADDR4;
                  dmy_r   <= `FWRS_DMY_WQIO;
                  kind_r  <= K_WRAPW;
                end
              end else if (op == `FWRS_OP_DISC_RD) begin
                state_r <= ST_ADDR;
                cnt_r   <= quad_command_mode ? `FWRS_CLK_ADDR4 : `FWRS_CLK_ADDR1;
                dmy_r   <= `FWRS_DMY_DISC;
                kind_r  <= K_DISC;
              end
            end
          end
          ST_ADDR: begin
            if (last) begin
              addr_r <= rx_nxt[ADDR_W-1:0];
              if (kind_r == K_WSET) begin
                state_r <= ST_WBITS;
                cnt_r   <= `FWRS_CLK_BYTE4;
              end else begin
                state_r <= ST_DUMMY;
                cnt_r   <= dmy_r;
              end
            end
          end
          ST_DUMMY: begin
            if (last) begin
              state_r <= ST_DATA;
              bit_r   <= 3'h0;
            end
          end
          ST_WBITS: begin
            if (last) begin
              state_r          <= ST_IGN;
              wrap_disable_bit <= op[`FWRS_W_DIS_BIT];
              wlen_r           <= op[`FWRS_W_LEN_HI:`FWRS_W_LEN_LO];
            end
          end
          ST_PARAM: begin
            if (last) begin
              state_r            <= ST_IGN;
              dummy_clock_select <= op[`FWRS_P_DSEL_HI:`FWRS_P_DSEL_LO];
              wlen_r             <= op[`FWRS_P_WLEN_HI:`FWRS_P_WLEN_LO];
            end
          end
          default: begin
            cnt_r <= cnt_r;
          end
        endcase
      end else if (sck_fall && state_r == ST_DATA) begin
        io_oe <= lane4_r ? 4'hf : 4'h2;
        if (bit_r == 3'h0) begin
          addr_r <= next_addr(addr_r, do_wrap, wlen_r);
          if (lane4_r) begin
            io_out <= byte_src[7:4];
            tx_r   <= {byte_src[3:0], 4'h0};
            bit_r  <= `FWRS_BITS4_LAST;
          end else begin
            io_out <= {2'b00, byte_src[7], 1'b0};
            tx_r   <= {byte_src[6:0], 1'b0};
            bit_r  <= `FWRS_BITS1_LAST;
          end
          tx_go_r <= 1'b1;
        end else begin
          bit_r <= bit_r - 3'h1;
          if (lane4_r) begin
            io_out <= tx_r[7:4];
            tx_r   <= {tx_r[3:0], 4'h0};
          end else begin
            io_out <= {2'b00, tx_r[7], 1'b0};
            tx_r   <= {tx_r[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule

// ### src/fwrs_regs.vh
// Purpose: Shared constants for the flash wrap, reset and discovery command logic
// Assumes: Included by bare name from the design file
// Notes:   Opcodes, phase lengths, reset values, field positions and timing
`ifndef FWRS_REGS_VH
`define FWRS_REGS_VH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FWRS_OP_RST_EN     8'h66
`define FWRS_OP_RST        8'h99
`define FWRS_OP_QPI_EN     8'h38
`define FWRS_OP_QPI_DIS    8'hff
`define FWRS_OP_WRAP_SET   8'h77
`define FWRS_OP_RD_PARAM   8'hc0
`define FWRS_OP_WRAP_RD    8'h0c
`define FWRS_OP_FAST_RD    8'h0b
`define FWRS_OP_QIO_RD     8'heb
`define FWRS_OP_WQIO_RD    8'he7
`define FWRS_OP_DISC_RD    8'h5a

// ----------------------------------------------------------------
// Phase lengths in serial clocks
// ----------------------------------------------------------------
`define FWRS_CLK_BYTE1     6'h08
`define FWRS_CLK_BYTE4     6'h02
`define FWRS_CLK_ADDR1     6'h18
`define FWRS_CLK_ADDR4     6'h06
`define FWRS_DMY_DISC      6'h08
`define FWRS_DMY_FAST1     6'h08
`define FWRS_DMY_QIO       6'h06
`define FWRS_DMY_WQIO      6'h04
`define FWRS_DMY_P0X       6'h04
`define FWRS_DMY_P10       6'h06
`define FWRS_DMY_P11       6'h08
`define FWRS_BITS1_LAST    3'h7
`define FWRS_BITS4_LAST    3'h1

// ----------------------------------------------------------------
// Reset values and field positions
// ----------------------------------------------------------------
`define FWRS_WDIS_RST      1'b1
`define FWRS_WLEN_RST      2'b00
`define FWRS_DSEL_RST      2'b00
`define FWRS_W_DIS_BIT     4
`define FWRS_W_LEN_HI      6
`define FWRS_W_LEN_LO      5
`define FWRS_P_DSEL_HI     5
`define FWRS_P_DSEL_LO     4
`define FWRS_P_WLEN_HI     1
`define FWRS_P_WLEN_LO     0
`define FWRS_WRAP_MIN_LEN  8'h08

// ----------------------------------------------------------------
// Discovery area
// ----------------------------------------------------------------
`define FWRS_DISC_AW       11
`define FWRS_DISC_HDR_LEN  11'h018
`define FWRS_DISC_MFR_IDX  5'h10
`define FWRS_DISC_ERASED   8'hff
`define FWRS_DISC_HDR      192'hff000080_02010000_ff000030_10010600_ff010106_50444653

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FWRS_T_RST_NS      30000
`define FWRS_REF_CLK_NS    50

`endif

// ### verif/flash_wrap_reset_sfdp_ctrl_test.sv
// Purpose: Self-checking bench for the wrap, reset and discovery command logic
// Assumes: Array byte is the low address byte xor 3ch
// Notes:   Host serial clock is free of the block clock phase
`include "fwrs_regs.vh"
module flash_wrap_reset_sfdp_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MFR = 8'ha5; // Arbitrary value
  logic        ref_clk, resetn, ce, quad_enable_bit, wel_set, susp_set, susp_clr;
  logic        cs_n, sck, quad_command_mode, wrap_disable_bit, write_enable_latch;
  logic        suspend_flag, reset_enabled, reset_busy, vol_clear;
  logic [1:0]  wrap_size_bits, wrap_length_select, dummy_clock_select;
  logic [3:0]  io_in, io_out, io_oe;
  logic [7:0]  mem_data, b;
  logic [23:0] mem_addr;
  int          miscompares, cmp_count;
  logic [7:0]  hdr [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01, 8'hff,
                             8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff,
                             MFR, 8'h00, 8'h01, 8'h02, 8'h80, 8'h00, 8'h00, 8'hff};
  assign mem_data = mem_addr[7:0] ^ 8'h3c;
  always #25 ref_clk = ~ref_clk;
  fwrs_ctrl #(.MFR_CODE(MFR)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .ce(ce), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_enable_bit), .wel_set(wel_set),
    .susp_set(susp_set), .susp_clr(susp_clr), .mem_data(mem_data), .mem_addr(mem_addr),
    .quad_command_mode(quad_command_mode), .wrap_disable_bit(wrap_disable_bit),
    .wrap_size_bits(wrap_size_bits), .wrap_length_select(wrap_length_select),
    .dummy_clock_select(dummy_clock_select), .write_enable_latch(write_enable_latch),
    .suspend_flag(suspend_flag), .reset_enabled(reset_enabled), .reset_busy(reset_busy),
    .vol_clear(vol_clear));
  fwrs_host i_host (.cs_n(cs_n), .sck(sck), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pulse(input logic [2:0] f);
    @(posedge ref_clk) #2 {wel_set, susp_set, susp_clr} = f;
    @(posedge ref_clk) #2 {wel_set, susp_set, susp_clr} = 3'b000;
  endtask
  task automatic frame(input bit q, input logic [7:0] op, input logic [31:0] a,
                       input int abits, input int dbits);
    i_host.start();
    i_host.send(q, {24'h0, op}, 8);
    i_host.send(q, a, abits);
    i_host.send(q, 32'h0, dbits);
  endtask
  task automatic disc_read(input int a, input int n);
    frame(1'b0, `FWRS_OP_DISC_RD, 32'(a), 24, 8);
    for (int k = 0; k < n; k++) begin
      i_host.get_byte(1'b0, b);
      check("disc_byte", b, (a + k < 24) ? hdr[a + k] : 8'hff);
    end
    i_host.stop();
    check("disc_oe_idle", io_oe, 4'h0);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (reset_busy !== 1'b0 && n < 700) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 700) begin
      miscompares++;
      results();
    end
  endtask
  task automatic wrap_set(input logic [7:0] w);
    i_host.start();
    i_host.send(1'b0, {24'h0, `FWRS_OP_WRAP_SET}, 8);
    i_host.send(1'b1, 32'h0, 24);
    i_host.send(1'b1, {24'h0, w}, 8);
    i_host.stop();
  endtask
  task automatic qio_read(input logic [7:0] op, input int dbits, input logic [23:0] a,
                          input logic [23:0] e);
    i_host.start();
    i_host.send(1'b0, {24'h0, op}, 8);
    i_host.send(1'b1, {8'h0, a}, 24);
    i_host.send(1'b1, 32'h0, dbits);
    for (int k = 0; k < 3; k++) begin
      i_host.get_byte(1'b1, b);
      check("qio_byte", b, e[23 - 8 * k -: 8] ^ 8'h3c);
    end
    i_host.stop();
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    quad_enable_bit = 1'b0;
    {wel_set, susp_set, susp_clr} = 3'b000;
    repeat (4) @(posedge ref_clk);
    #2 resetn = 1'b1;
    repeat (2) @(posedge ref_clk);
    check("wrap_dis", wrap_disable_bit, 1'b1);
    check("defaults", {quad_command_mode, wrap_length_select, dummy_clock_select}, 5'h00);
    disc_read(0, 24);
    disc_read(11'h7fe, 2);
    frame(1'b0, `FWRS_OP_RD_PARAM, 32'h31, 8, 0);
    i_host.stop();
    check("param_serial", {wrap_length_select, dummy_clock_select}, 4'h0);
    i_host.cmd(1'b0, `FWRS_OP_QPI_EN);
    check("quad_no_qe", quad_command_mode, 1'b0);
    @(posedge ref_clk) #2 quad_enable_bit = 1'b1;
    wrap_set(8'h40);
    check("wrap_set", {wrap_disable_bit, wrap_size_bits}, 3'b010);
    qio_read(`FWRS_OP_QIO_RD, 24, 24'h00021e, 24'h1e1f00);
    wrap_set(8'h50);
    check("wrap_off", {wrap_disable_bit, wrap_size_bits}, 3'b110);
    qio_read(`FWRS_OP_QIO_RD, 24, 24'h00021e, 24'h1e1f20);
    qio_read(`FWRS_OP_WQIO_RD, 16, 24'h00023e, 24'h3e3f40);
    i_host.cmd(1'b0, `FWRS_OP_QPI_EN);
    check("quad_len", {quad_command_mode, wrap_length_select}, 3'b110);
    frame(1'b1, `FWRS_OP_RD_PARAM, 32'h31, 8, 0);
    i_host.stop();
    check("param_quad", {dummy_clock_select, wrap_length_select}, 4'hd);
    frame(1'b1, `FWRS_OP_WRAP_RD, 32'h00010e, 24, 32);
    for (int k = 0; k < 4; k++) begin
      i_host.get_byte(1'b1, b);
      check("wrap_byte", b, {4'h0, 4'(14 + k)} ^ 8'h3c);
    end
    i_host.stop();
    i_host.cmd(1'b1, `FWRS_OP_QPI_DIS);
    check("qpi_off", {quad_command_mode, dummy_clock_select, wrap_length_select}, 5'h0d);
    i_host.cmd(1'b0, `FWRS_OP_QPI_EN);
    check("quad_back", quad_command_mode, 1'b1);
    pulse(3'b111);
    check("flags_set", {write_enable_latch, suspend_flag}, 2'b11);
    i_host.cmd(1'b1, `FWRS_OP_RST_EN);
    check("rst_armed", reset_enabled, 1'b1);
    i_host.cmd(1'b1, `FWRS_OP_FAST_RD);
    check("rst_disarmed", reset_enabled, 1'b0);
    i_host.cmd(1'b1, `FWRS_OP_RST);
    check("no_reset", {reset_busy, write_enable_latch}, 2'b01);
    i_host.cmd(1'b1, `FWRS_OP_RST_EN);
    i_host.cmd(1'b1, `FWRS_OP_RST);
    check("after_rst", {reset_busy, quad_command_mode, wrap_disable_bit, wrap_length_select,
          dummy_clock_select, write_enable_latch, suspend_flag}, 9'h140);
    i_host.cmd(1'b0, `FWRS_OP_QPI_EN);
    check("busy_ignore", quad_command_mode, 1'b0);
    wait_idle();
    check("busy_done", reset_busy, 1'b0);
    pulse(3'b100);
    check("pre_rst_idle", {reset_busy, suspend_flag}, 2'b00);
    i_host.cmd(1'b0, `FWRS_OP_RST_EN);
    i_host.cmd(1'b0, `FWRS_OP_RST);
    check("serial_rst", {reset_busy, write_enable_latch}, 2'b10);
    wait_idle();
    results();
  end
endmodule

// ### verif/fwrs_ctrl_asserts.sv
// Purpose: Port-level assertions for the wrap, reset and discovery command logic
// Assumes: Single block clock domain; bound to every fwrs_ctrl instance
// Notes:   Reset recovery is counted in block clocks (601 of them)
module fwrs_ctrl_asserts (
  input wire       ref_clk,
  input wire       resetn,
  input wire       cs_n,
  input wire       quad_enable_bit,
  input wire [3:0] io_oe,
  input wire       quad_command_mode,
  input wire       wrap_disable_bit,
  input wire [1:0] wrap_size_bits,
  input wire [1:0] wrap_length_select,
  input wire [1:0] dummy_clock_select,
  input wire       write_enable_latch,
  input wire       suspend_flag,
  input wire       reset_busy,
  input wire       vol_clear
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Recovery counter
  // ----------------------------------------------------------------
  logic [9:0] busy_cnt_r;
  wire  [9:0] busy_cnt_nxt = reset_busy ? busy_cnt_r + 10'h001 : 10'h000;
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_r <= 10'h000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_wdis_power_on: assert property ($rose(resetn) |-> wrap_disable_bit)
    else $error("wrap disable bit low after reset");
  a_clear_starts_busy: assert property (vol_clear |-> ##2 reset_busy)
    else $error("recovery not flagged after reset command");
  a_clear_defaults: assert property (vol_clear |-> ##2 (wrap_disable_bit &&
    wrap_length_select == 2'b00 && dummy_clock_select == 2'b00 && !quad_command_mode &&
    !write_enable_latch && !suspend_flag))
    else $error("volatile state not back to defaults");
  a_busy_length: assert property ($fell(reset_busy) |-> busy_cnt_r == 10'h259)
    else $error("recovery window length wrong");
  a_busy_frozen: assert property (reset_busy && $past(reset_busy, 2) |->
    $stable(quad_command_mode) && $stable(dummy_clock_select) && $stable(wrap_disable_bit))
    else $error("state changed during recovery");
  a_cs_high_idle: assert property (cs_n [*5] |-> io_oe == 4'h0)
    else $error("pins driven while deselected");
  a_oe_codes: assert property (io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'hf)
    else $error("illegal output enable pattern");
  a_quad_oe_nibble: assert property (quad_command_mode && io_oe != 4'h0 |-> io_oe == 4'hf)
    else $error("quad mode data not on all four lines");
  a_quad_entry: assert property ($rose(quad_command_mode) |-> quad_enable_bit && !reset_busy)
    else $error("quad mode entered without quad enable");
  a_dsel_quad_only: assert property ($changed(dummy_clock_select) |->
    $past(quad_command_mode) || vol_clear || $past(vol_clear))
    else $error("dummy select changed outside quad mode");
  a_wrap_mirror: assert property (wrap_size_bits == wrap_length_select)
    else $error("wrap size and wrap length disagree");
  a_mode_keeps_len: assert property ($changed(quad_command_mode) && !vol_clear |->
    $stable(wrap_size_bits))
    else $error("wrap length changed on mode switch");
  c_reset_taken: cover property (vol_clear);
  c_quad_entered: cover property ($rose(quad_command_mode));
  c_quad_data: cover property (io_oe == 4'hf);
  c_serial_data: cover property (io_oe == 4'h2);
endmodule

bind fwrs_ctrl fwrs_ctrl_asserts i_chk (
  .ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .quad_enable_bit(quad_enable_bit),
  .io_oe(io_oe), .quad_command_mode(quad_command_mode), .wrap_disable_bit(wrap_disable_bit),
  .wrap_size_bits(wrap_size_bits), .wrap_length_select(wrap_length_select),
  .dummy_clock_select(dummy_clock_select), .write_enable_latch(write_enable_latch),
  .suspend_flag(suspend_flag), .reset_busy(reset_busy), .vol_clear(vol_clear)
);

// ### verif/fwrs_host.sv
// Purpose: Behavioural host controller driving chip select, serial clock and data lines
// Assumes: Mode 0 clocking, 400 ns serial clock, clock parked low between frames
// Notes:   Released lines show an inverting pattern instead of a held value
module fwrs_host (
  output logic       cs_n,
  output logic       sck,
  output logic [3:0] io_in,
  input  wire  [3:0] io_out,
  input  wire  [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_in = 4'h5;
  end
  // ----------------------------------------------------------------
  // One clock: drive after the fall, take the wire just before the next fall
  // ----------------------------------------------------------------
  task automatic tick(input logic [3:0] d, output logic [3:0] r);
    io_in = d;
    #200 sck = 1'b1;
    #200 r = (io_out & io_oe) | (io_in & ~io_oe);
    sck = 1'b0;
  endtask
  task automatic send(input bit q, input logic [31:0] v, input int nbits);
    logic [31:0] sh;
    logic [3:0]  r;
    sh = v << (32 - nbits);
    repeat (q ? nbits / 4 : nbits) begin
      tick(q ? sh[31:28] : {~io_in[3:1], sh[31]}, r);
      sh = q ? sh << 4 : sh << 1;
    end
  endtask
  task automatic get_byte(input bit q, output logic [7:0] b);
    logic [3:0] r;
    repeat (q ? 2 : 8) begin
      tick(~io_in, r);
      b = q ? {b[3:0], r} : {b[6:0], r[1]};
    end
  endtask
  task automatic start;
    #13 cs_n = 1'b0;
  endtask
  task automatic stop;
    #100 cs_n = 1'b1;
    io_in = ~io_in;
    #400;
  endtask
  task automatic cmd(input bit q, input logic [7:0] op);
    start();
    send(q, {24'h0, op}, 8);
    stop();
  endtask
endmodule
